// ### include/fpi_defs.svh
// Offsets, field widths and timing counts of the pull-control slave.
// Assumes a 50 MHz system clock.
`ifndef FPI_DEFS_SVH
`define FPI_DEFS_SVH
`define FPI_REG_LOWER        8'h00
`define FPI_REG_UPPER        8'h01
`define FPI_REG_RANGE        8'h02
`define FPI_UPPER_W          10
`define FPI_RANGE_W          4
`define FPI_CLK_MHZ          50
`define FPI_DELAY_US         103
`define FPI_DELAY_CYC        (`FPI_DELAY_US * `FPI_CLK_MHZ)
`define FPI_SETTLE_NS        16500
`define FPI_SETTLE_CYC       ((`FPI_SETTLE_NS * `FPI_CLK_MHZ) / 1000)
`endif

// ### include/fpi_pkg.sv
// Types shared by the pull-control slave files.
// Assumes nothing of its surroundings.
package fpi_pkg;
   typedef enum logic [2:0] {
      FPI_IDLE  = 3'b000,
      FPI_ADDR  = 3'b001,
      FPI_AACK  = 3'b010,
      FPI_RX    = 3'b011,
      FPI_RACK  = 3'b100,
      FPI_TX    = 3'b101,
      FPI_TACK  = 3'b110
   } fpi_state_t;
   typedef enum logic [1:0] {
      FPI_PULL_IDLE   = 2'b00,
      FPI_PULL_DELAY  = 2'b01,
      FPI_PULL_SETTLE = 2'b10
   } fpi_pull_t;
endpackage

// ### rtl/fpi_fifo.sv
// Small flop FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset copy.
`timescale 1ns/1ps
module fpi_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output      logic             in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output      logic             out_valid_o,
   input  wire logic             out_ready_i,
   output      logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
      $error("DEPTH must be a power of two of at least two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire              push = in_valid_i && in_ready_o;
   wire              pop  = out_valid_o && out_ready_i;
   assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end
   always_ff @(posedge clock_i) begin
      if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
   end
endmodule

// ### rtl/fpi_slave.sv
// Two-wire slave port of a digitally pulled oscillator with its control registers.
// Assumes SCL and SDA arrive asynchronously; SDA pull-up lives outside.
//
// Functional notes
// - Four-bit pull-range field, bits 3:0, sixteen ascending symmetric ranges.
// - Range register bits 15:4 read zero, writes ignored.
// - Range field loads a factory value at reset, master may overwrite.
// - Slave only, never drives SCL, works up to 1 Mbit/s.
// - SDA driver changes only while SCL low, once per bit.
// - Start is SDA falling, stop SDA rising, both with SCL high.
// - Repeated start restarts address reception without a stop.
// - Bytes are eight bits, MSB first, unlimited count.
// - Ninth clock carries acknowledge; low means ACK, high means NACK.
// - NACK only a foreign device address; ACK all else.
// - After master ACK of final word, release SDA for stop.
// - On master NACK keep sending next data bits anyway.
// - Seven-bit device address then direction bit, one reads.
// - First byte after write address is the 8-bit register address.
// - Register address advances per word, wrapping 255 to 0.
// - Each register is two bytes, upper byte first.
// - Read without address starts at counter, zero after reset.
// - Pull starts within 140 us, typically 103, after upper write.
// - Pull settles within 20 us, typically 16.5, after start.
// - 26-bit two's complement pull value from registers 0 and 1.
// - New pull value applied only when the upper word loads.
`timescale 1ns/1ps
`include "fpi_defs.svh"
module fpi_slave #(
   parameter logic [6:0] DEV_ADDR      = 7'h60,
   parameter logic [3:0] RANGE_DEFAULT = 4'h0,
   parameter int         DELAY_CYC     = `FPI_DELAY_CYC,
   parameter int         SETTLE_CYC    = `FPI_SETTLE_CYC
) (
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output      logic        sda_o,
   output      logic        sda_oe_o,
   output      logic [25:0] pull_value_o,
   output      logic [3:0]  pull_range_o,
   output      logic        pull_active_o,
   output      logic        pull_settled_o
);
   if (DELAY_CYC < 1 || SETTLE_CYC < 1 || DELAY_CYC > 16777216 || SETTLE_CYC > 16777216) begin : g_bad_timing
      $error("Timing counts must be positive and fit the counter");
   end

   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_sync;
   logic       rst_n;
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_q;
   logic       sda_q;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   always_ff @(posedge clock_i) begin
      if (!rst_n) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_i};
         sda_sync <= {sda_sync[0], sda_i};
         scl_q    <= scl_sync[1];
         sda_q    <= sda_sync[1];
      end
   end

   wire scl      = scl_sync[1];
   wire sda      = sda_sync[1];
   wire scl_rise = scl && !scl_q;
   wire scl_fall = !scl && scl_q;
   wire start_c  = scl && scl_q && !sda && sda_q;
   wire stop_c   = scl && scl_q && sda && !sda_q;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [15:0] lower_control_word;
   logic [9:0]  upper_control_word;
   logic [3:0]  frequency_pull_range;
   logic [7:0]  reg_ptr;
   logic [7:0]  hi_byte;

   logic [15:0] rd_word;
   assign rd_word = (reg_ptr == `FPI_REG_LOWER) ? lower_control_word :
                    (reg_ptr == `FPI_REG_UPPER) ? {6'h00, upper_control_word} :
                    (reg_ptr == `FPI_REG_RANGE) ? {12'h000, frequency_pull_range} :
                    16'h0000;

   // ------------------------------------------------------------
   // Bus state machine
   // ------------------------------------------------------------
   fpi_pkg::fpi_state_t state;
   logic [7:0] shreg;
   logic [3:0] bitcnt;
   logic       byte_sel;
   logic       addr_phase;
   logic       drive_low;
   logic       wr_valid;
   logic [7:0] wr_addr;
   logic [15:0] wr_data;

   wire        addr_match = shreg[7:1] == DEV_ADDR;
   wire [7:0]  tx_byte    = byte_sel ? rd_word[7:0] : rd_word[15:8];

   always_ff @(posedge clock_i) begin
      if (!rst_n) begin
         state      <= fpi_pkg::FPI_IDLE;
         shreg      <= 8'h00;
         bitcnt     <= 4'h0;
         byte_sel   <= 1'b0;
         addr_phase <= 1'b0;
         drive_low  <= 1'b0;
         reg_ptr    <= 8'h00;
         hi_byte    <= 8'h00;
         wr_valid   <= 1'b0;
         wr_addr    <= 8'h00;
         wr_data    <= 16'h0000;
      end else begin
         wr_valid <= 1'b0;
         if (start_c) begin
            state     <= fpi_pkg::FPI_ADDR;
            bitcnt    <= 4'h0;
            drive_low <= 1'b0;
         end else if (stop_c) begin
            state     <= fpi_pkg::FPI_IDLE;
            drive_low <= 1'b0;
         end else begin
            case (state)
               fpi_pkg::FPI_IDLE: begin
                  drive_low <= 1'b0;
               end
               fpi_pkg::FPI_ADDR, fpi_pkg::FPI_RX: begin
                  if (scl_rise) begin
                     shreg  <= {shreg[6:0], sda};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     bitcnt <= 4'h0;
                     if (state == fpi_pkg::FPI_ADDR) begin
                        if (addr_match) begin
                           drive_low  <= 1'b1;
                           state      <= fpi_pkg::FPI_AACK;
                           byte_sel   <= 1'b0;
                           addr_phase <= !shreg[0];
                        end else begin
                           state <= fpi_pkg::FPI_IDLE;
                        end
                     end else begin
                        drive_low <= 1'b1;
                        state     <= fpi_pkg::FPI_RACK;
                        if (addr_phase) begin
                           reg_ptr    <= shreg;
                           addr_phase <= 1'b0;
                           byte_sel   <= 1'b0;
                        end else if (!byte_sel) begin
                           hi_byte  <= shreg;
                           byte_sel <= 1'b1;
                        end else begin
                           wr_valid <= 1'b1;
                           wr_addr  <= reg_ptr;
                           wr_data  <= {hi_byte, shreg};
                           reg_ptr  <= reg_ptr + 8'h01;
                           byte_sel <= 1'b0;
                        end
                     end
                  end
               end
               fpi_pkg::FPI_AACK: begin
                  if (scl_fall) begin
                     if (shreg[0]) begin
                        state     <= fpi_pkg::FPI_TX;
                        shreg     <= tx_byte;
                        drive_low <= !tx_byte[7];
                        bitcnt    <= 4'h0;
                     end else begin
                        state     <= fpi_pkg::FPI_RX;
                        drive_low <= 1'b0;
                     end
                  end
               end
               fpi_pkg::FPI_RACK: begin
                  if (scl_fall) begin
                     state     <= fpi_pkg::FPI_RX;
                     drive_low <= 1'b0;
                  end
               end
               fpi_pkg::FPI_TX: begin
                  if (scl_rise) begin
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        drive_low <= 1'b0;
                        state     <= fpi_pkg::FPI_TACK;
                        if (byte_sel) begin
                           reg_ptr <= reg_ptr + 8'h01;
                        end
                        byte_sel <= !byte_sel;
                     end else begin
                        shreg     <= {shreg[6:0], 1'b0};
                        drive_low <= !shreg[6];
                     end
                  end
               end
               fpi_pkg::FPI_TACK: begin
                  if (scl_rise) begin
                     shreg <= {7'h00, sda};
                  end else if (scl_fall) begin
                     bitcnt <= 4'h0;
                     if (!shreg[0] && !byte_sel) begin
                        state     <= fpi_pkg::FPI_IDLE;
                        drive_low <= 1'b0;
                     end else begin
                        state     <= fpi_pkg::FPI_TX;
                        shreg     <= tx_byte;
                        drive_low <= !tx_byte[7];
                     end
                  end
               end
               default: begin
                  state <= fpi_pkg::FPI_IDLE;
               end
            endcase
         end
      end
   end

   // Open-drain data; SCL is never driven
   assign sda_o    = 1'b0;
   assign sda_oe_o = drive_low;

   // ------------------------------------------------------------
   // Write queue and register update
   // ------------------------------------------------------------
   logic        q_valid;
   logic [23:0] q_data;
   logic        q_ready;
   logic        q_in_ready;
   fpi_fifo #(
      .WIDTH(24),
      .DEPTH(4)
   ) u_wq (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n),
      .in_valid_i (wr_valid),
      .in_ready_o (q_in_ready),
      .in_data_i  ({wr_addr, wr_data}),
      .out_valid_o(q_valid),
      .out_ready_i(q_ready),
      .out_data_o (q_data)
   );

   fpi_pkg::fpi_pull_t pull_st;
   logic [23:0] pull_cnt;
   wire         q_is_upper = q_data[23:16] == `FPI_REG_UPPER;
   // Upper word waits until the previous pull has started
   assign q_ready = !(q_is_upper && pull_st == fpi_pkg::FPI_PULL_DELAY);

   logic [25:0] pending;
   always_ff @(posedge clock_i) begin
      if (!rst_n) begin
         lower_control_word   <= 16'h0000;
         upper_control_word   <= 10'h000;
         frequency_pull_range <= RANGE_DEFAULT;
         pull_value_o         <= 26'h0000000;
         pending              <= 26'h0000000;
         pull_st              <= fpi_pkg::FPI_PULL_IDLE;
         pull_cnt             <= 24'h000000;
         pull_active_o        <= 1'b0;
         pull_settled_o       <= 1'b1;
      end else begin
         if (q_valid && q_ready) begin
            case (q_data[23:16])
               `FPI_REG_LOWER: lower_control_word <= q_data[15:0];
               `FPI_REG_UPPER: begin
                  upper_control_word <= q_data[9:0];
                  pending  <= {q_data[9:0], lower_control_word};
                  pull_st  <= fpi_pkg::FPI_PULL_DELAY;
                  pull_cnt <= 24'(DELAY_CYC - 1);
                  pull_settled_o <= 1'b0;
                  pull_active_o  <= 1'b0;
               end
               `FPI_REG_RANGE: frequency_pull_range <= q_data[3:0];
               default: ;
            endcase
         end
         case (pull_st)
            fpi_pkg::FPI_PULL_DELAY: begin
               if (pull_cnt == 24'h000000) begin
                  pull_value_o  <= pending;
                  pull_active_o <= 1'b1;
                  pull_st       <= fpi_pkg::FPI_PULL_SETTLE;
                  pull_cnt      <= 24'(SETTLE_CYC - 1);
               end else begin
                  pull_cnt <= pull_cnt - 24'h000001;
               end
            end
            fpi_pkg::FPI_PULL_SETTLE: begin
               if (!(q_valid && q_ready && q_is_upper)) begin
                  if (pull_cnt == 24'h000000) begin
                     pull_settled_o <= 1'b1;
                     pull_active_o  <= 1'b0;
                     pull_st        <= fpi_pkg::FPI_PULL_IDLE;
                  end else begin
                     pull_cnt <= pull_cnt - 24'h000001;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   assign pull_range_o = frequency_pull_range;
endmodule

// ### dv/fpi_slave_chk.sv
// Concurrent checks on the ports of the pull-control slave.
// Assumes it is bound into fpi_slave; bus pins move off the rising edge.
`timescale 1ns/1ps
module fpi_slave_chk #(
   parameter logic [3:0] RANGE_DEFAULT = 4'h0,
   parameter int         DELAY_CYC     = 5150,
   parameter int         SETTLE_CYC    = 825
) (
   input wire logic        clock_i,
   input wire logic        arst_n_i,
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic [25:0] pull_value_o,
   input wire logic [3:0]  pull_range_o,
   input wire logic        pull_active_o,
   input wire logic        pull_settled_o
);
   // --------------------
   // Pull timing counters
   // --------------------
   int dly_cnt;
   int stl_cnt;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dly_cnt <= 0;
         stl_cnt <= 0;
      end else begin
         dly_cnt <= (!pull_settled_o && !pull_active_o) ? dly_cnt + 1 : 0;
         stl_cnt <= pull_active_o ? stl_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   // --------------------
   // Properties
   // --------------------
   property p_oe_scl_low;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda enable moved with scl high");
   property p_oe_once;
      $changed(sda_oe_o) |=> $stable(sda_oe_o) [*3];
   endproperty
   a_oe_once: assert property (p_oe_once) else $error("sda enable moved twice in a bit");
   property p_open_drain;
      sda_o == 1'h0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda driven high");
   property p_start_release;
      scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe_o [*8];
   endproperty
   a_start_release: assert property (p_start_release) else $error("sda held after start");
   property p_reset_vals;
      $rose(arst_n_i) |-> pull_range_o == RANGE_DEFAULT && pull_value_o == 26'h0 && pull_settled_o && !pull_active_o;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
   property p_value_at_start;
      $changed(pull_value_o) |-> ##[0:1] $rose(pull_active_o);
   endproperty
   a_value_at_start: assert property (p_value_at_start) else $error("pull value moved outside pull start");
   property p_delay_exact;
      $rose(pull_active_o) |-> dly_cnt >= DELAY_CYC - 3 && dly_cnt <= DELAY_CYC + 3;
   endproperty
   a_delay_exact: assert property (p_delay_exact) else $error("pull start delay wrong");
   property p_delay_bound;
      dly_cnt <= DELAY_CYC + 3;
   endproperty
   a_delay_bound: assert property (p_delay_bound) else $error("pull start overdue");
   property p_settle;
      $rose(pull_settled_o) |-> $past(pull_active_o) && stl_cnt >= SETTLE_CYC - 2 && stl_cnt <= SETTLE_CYC + 2;
   endproperty
   a_settle: assert property (p_settle) else $error("settle time wrong");
   cover property ($rose(pull_active_o));
   cover property ($rose(sda_oe_o));
   cover property (scl_i && $fell(sda_i));
endmodule
bind fpi_slave fpi_slave_chk #(.RANGE_DEFAULT(RANGE_DEFAULT), .DELAY_CYC(DELAY_CYC), .SETTLE_CYC(SETTLE_CYC))
   chk_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .pull_value_o(pull_value_o), .pull_range_o(pull_range_o),
   .pull_active_o(pull_active_o), .pull_settled_o(pull_settled_o));

// ### dv/fpi_master.sv
// Behavioural two-wire bus master: drives SCL, pulls SDA low.
// Assumes SDA is resolved outside with a pull-up; one bit is 8 clocks.
`timescale 1ns/1ps
module fpi_master (
   input  wire logic clock_i,
   input  wire logic sda_i,
   output      logic scl_o,
   output      logic sda_low_o
);
   initial begin
      scl_o = 1'h1;
      sda_low_o = 1'h0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // Data moves mid low phase, sampled at end of high phase
   task automatic bit_io(input logic b, output logic r);
      wait_clk(2);
      sda_low_o = ~b;
      wait_clk(3);
      scl_o = 1'h1;
      wait_clk(3);
      r = sda_i;
      scl_o = 1'h0;
   endtask
   task automatic start();
      if (!scl_o) begin
         wait_clk(2);
         sda_low_o = 1'h0;
         wait_clk(3);
         scl_o = 1'h1;
         wait_clk(2);
      end
      sda_low_o = 1'h1;
      wait_clk(4);
      scl_o = 1'h0;
   endtask
   task automatic stop();
      wait_clk(2);
      sda_low_o = 1'h1;
      wait_clk(3);
      scl_o = 1'h1;
      wait_clk(2);
      sda_low_o = 1'h0;
      wait_clk(4);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'h1, r);
      ack = ~r;
   endtask
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'h1, d[i]);
      end
      bit_io(~ack, r);
   endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the pull-control slave against a register model.
// Assumes fpi_slave, fpi_fifo, fpi_master and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
   localparam logic [6:0] ADDR = 7'h60;
   localparam logic [3:0] RDEF = 4'h5;
   logic        clock_i = 1'h0;
   logic        arst_n_i = 1'h0;
   logic        scl, sda, sda_o, sda_oe_o, m_low, ack, pull_active_o, pull_settled_o;
   logic [25:0] pull_value_o;
   logic [3:0]  pull_range_o;
   int          num_errors = 0;
   int          comparisons = 0;
   int          lower = 0, upper = 0, rng = RDEF, ptr = 0;
   always #10 clock_i = ~clock_i;
   assign sda = ~(m_low | (sda_oe_o & ~sda_o));
   fpi_slave #(.DEV_ADDR(ADDR), .RANGE_DEFAULT(RDEF), .DELAY_CYC(40), .SETTLE_CYC(5)) dut_u (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .pull_value_o(pull_value_o), .pull_range_o(pull_range_o), .pull_active_o(pull_active_o),
      .pull_settled_o(pull_settled_o));
   fpi_master m_u (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
   // --------------------
   // Checking and model
   // --------------------
   task automatic stop_test();
      $display("Comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   function automatic int model_rd(input int r);
      return r == 0 ? lower : r == 1 ? upper : r == 2 ? rng : 0;
   endfunction
   task automatic send(input logic [7:0] d);
      m_u.wr_byte(d, ack);
      check(ack, 1'h1);
   endtask
   task automatic wr_regs(input int r, input int w[$]);
      int v;
      m_u.start();
      send({ADDR, 1'h0});
      send(r[7:0]);
      ptr = r;
      foreach (w[k]) begin
         v = w[k];
         send(v[15:8]);
         send(v[7:0]);
         case (ptr)
            0: lower = v & 32'hFFFF;
            1: upper = v & 32'h3FF;
            2: rng = v & 32'hF;
            default: ;
         endcase
         ptr = (ptr + 1) % 256;
      end
      m_u.stop();
   endtask
   task automatic rd_regs(input int r, input int n);
      logic [7:0] hi, lo;
      if (r >= 0) begin
         m_u.start();
         send({ADDR, 1'h0});
         send(r[7:0]);
         ptr = r;
      end
      m_u.start();
      send({ADDR, 1'h1});
      for (int k = 0; k < n; k++) begin
         m_u.rd_byte(1'h1, hi);
         m_u.rd_byte(k == n - 1, lo);
         check({hi, lo}, model_rd(ptr));
         ptr = (ptr + 1) % 256;
      end
      m_u.stop();
   endtask
   task automatic wait_for(input logic active);
      int n = 0;
      while ((active ? pull_active_o : pull_settled_o) !== 1'h1 && n < 300) begin
         @(negedge clock_i);
         n++;
      end
      if (n == 300) begin
         num_errors++;
         stop_test();
      end
   endtask
   // --------------------
   // Scenarios
   // --------------------
   initial begin
      void'($urandom(32'hA4841CF2));
      repeat (3) @(negedge clock_i);
      arst_n_i = 1'h1;
      repeat (10) @(negedge clock_i);
      check(pull_range_o, RDEF);
      check(pull_value_o, 26'h0);
      rd_regs(-1, 3);
      m_u.start();
      m_u.wr_byte({ADDR ^ 7'h01, 1'h0}, ack);
      check(ack, 1'h0);
      m_u.stop();
      for (int c = 0; c < 16; c++) begin
         wr_regs(2, '{($urandom & 32'hFFF0) | c});
         check(pull_range_o, c[3:0]);
         rd_regs(2, 1);
      end
      wr_regs(255, '{$urandom & 32'hFFFF, $urandom & 32'hFFFF});
      rd_regs(255, 3);
      repeat (100) @(negedge clock_i);
      check(pull_value_o, 26'h0);
      for (int k = 0; k < 2; k++) begin
         if (k == 0) begin
            wr_regs(1, '{$urandom & 32'hFFFF});
         end else begin
            wr_regs(0, '{$urandom & 32'hFFFF, $urandom & 32'hFFFF});
         end
         check(pull_settled_o, 1'h0);
         wait_for(1'h1);
         check(pull_value_o, {upper[9:0], lower[15:0]});
         wait_for(1'h0);
         check(pull_active_o, 1'h0);
         rd_regs(0, 2);
      end
      // Mid-run reset brings back factory range and zero pointer
      arst_n_i = 1'h0;
      repeat (3) @(negedge clock_i);
      arst_n_i = 1'h1;
      lower = 0;
      upper = 0;
      rng = RDEF;
      ptr = 0;
      repeat (10) @(negedge clock_i);
      check(pull_range_o, RDEF);
      check(pull_value_o, 26'h0);
      check(pull_settled_o, 1'h1);
      rd_regs(-1, 3);
      stop_test();
   end
endmodule
